// File: common/tcmo_cfg.svh
`ifndef TCMO_CFG_SVH
`define TCMO_CFG_SVH
`define TCMO_CNT_W       16
`define TCMO_CNT_MAX     16'hffff
`define TCMO_CNT_BOTTOM  16'h0000
`define TCMO_TOP_8BIT    16'h00ff
`define TCMO_TOP_9BIT    16'h01ff
`define TCMO_TOP_10BIT   16'h03ff
`define TCMO_WGM_NORMAL  4'h0
`define TCMO_WGM_CTC_OCR 4'h4
`define TCMO_WGM_FP8     4'h5
`define TCMO_WGM_FP9     4'h6
`define TCMO_WGM_FP10    4'h7
`define TCMO_WGM_CTC_ICR 4'hc
`define TCMO_WGM_FP_ICR  4'he
`define TCMO_WGM_FP_OCR  4'hf
`define TCMO_COM_OFF     2'h0
`define TCMO_COM_TOGGLE  2'h1
`define TCMO_COM_CLEAR   2'h2
`define TCMO_COM_SET     2'h3
`define TCMO_OC_RST      1'b0
`endif

// File: common/tcmo_pkg.sv
package tcmo_pkg;
    typedef logic [15:0] tcmo_count_t;
    typedef enum logic [1:0] {
        TCMO_CLS_NONPWM = 2'b00,
        TCMO_CLS_FAST   = 2'b01,
        TCMO_CLS_OTHER  = 2'b10
    } tcmo_class_e;
endpackage

// File: logic/tcmo_timer.sv
// Operation
// R1 - Reset clears the internal output state to zero, regardless of pin level.
// R2 - Nonzero output mode replaces port output value with output state; direction unchanged.
// R3 - Pin drives the waveform only while its direction bit selects output.
// R4 - Output state can be preset before the pin output is enabled.
// R5 - Output mode setting never affects the input capture function.
// R6 - Output mode zero leaves the output state unchanged on compare match.
// R7 - A new output mode acts from the first compare match after writing.
// R8 - In non-PWM modes the force strobe applies the match action immediately.
// R9 - Counting depends only on waveform mode; output mode only shapes output.
// R10 - Mode 0 always increments, never clears on match, wraps ffff to 0000.
// R11 - Normal mode sets overflow flag in the cycle the counter becomes zero.
// R12 - Hardware only sets overflow flag; servicing clears it.
// R13 - Normal mode accepts counter writes at any time.
// R14 - Clear-on-match clears counter at compare A (mode 4) or capture (12).
// R15 - Clear-on-match top sets compare A match flag or capture flag.
// R16 - Unbuffered top below count makes counter run to ffff and wrap first.
// R17 - Clear-on-match output mode 1 toggles channel A output on each match.
// R18 - Clear-on-match sets overflow flag when counter passes max to zero.
// R19 - Modes 5, 6, 7, 14, 15 are fast PWM, single slope bottom to top.
// R20 - Fast PWM non-inverting sets on match, clears at top; inverting reverses.
// R21 - Fast PWM top fixed ff, 1ff, 3ff, or capture (14) or compare A (15).
// R22 - Fast PWM output mode two non-inverted, three inverted.
// R23 - Fast PWM compare A is double buffered, loaded when counter matches top.
// R24 - Non-PWM output modes 1, 2, 3 toggle, clear, set on match.
// R25 - State advances only on prescaler enable pulses; all on system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcmo_cfg.svh"
module tcmo_timer (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        timer_tick,
    input  wire logic [3:0]  waveform_gen_mode,
    input  wire logic [1:0]  compare_output_mode_chan_a,
    input  wire logic        force_compare_strobe,
    input  wire logic        counter_wr,
    input  wire logic [15:0] counter_wdata,
    input  wire logic        compare_reg_wr,
    input  wire logic [15:0] compare_reg_wdata,
    input  wire logic [15:0] capture_reg,
    input  wire logic        overflow_clr,
    input  wire logic        match_clr,
    input  wire logic        capture_clr,
    input  wire logic        capture_event,
    input  wire logic        pin_direction_bit,
    input  wire logic        port_out_bit,
    output logic [15:0]      counter_value,
    output logic [15:0]      compare_reg_chan_a,
    output logic             overflow_flag,
    output logic             match_flag_chan_a,
    output logic             capture_flag,
    output logic             compare_output_state_chan_a,
    output logic             pin_out,
    output logic             pin_oe
);
    tcmo_pkg::tcmo_count_t cnt_reg, cnt_next, ocr_reg, ocr_next, buf_reg, buf_next;
    logic                  tov_reg, tov_next, ocf_reg, ocf_next, icf_reg, icf_next;
    logic                  oc_reg, oc_next, blk_reg, blk_next;
    logic                  pout_reg, pout_next, poe_reg, poe_next;
    logic                  cap_s1_reg, cap_s2_reg, cap_d_reg;
    tcmo_pkg::tcmo_class_e cls;
    tcmo_pkg::tcmo_count_t top;
    logic                  at_top, match, tick, cap_edge, ctc_top_icr;

    // Capture pin synchronised; the edge feeds only the capture flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cap_s1_reg <= 1'b0;
            cap_s2_reg <= 1'b0;
            cap_d_reg  <= 1'b0;
        end else if (clk_en) begin
            cap_s1_reg <= capture_event;
            cap_s2_reg <= cap_s1_reg;
            cap_d_reg  <= cap_s2_reg;
        end
    end

    always_comb begin
        tick = clk_en && timer_tick; // R25
        cap_edge = cap_s2_reg && !cap_d_reg; // R5
        ctc_top_icr = 1'b0;
        // R9
        case (waveform_gen_mode)
            `TCMO_WGM_NORMAL: begin
                cls = tcmo_pkg::TCMO_CLS_NONPWM;
                top = `TCMO_CNT_MAX; // R10
            end
            `TCMO_WGM_CTC_OCR: begin
                cls = tcmo_pkg::TCMO_CLS_NONPWM;
                top = ocr_reg; // R14
            end
            `TCMO_WGM_CTC_ICR: begin
                cls = tcmo_pkg::TCMO_CLS_NONPWM;
                top = capture_reg; // R14
                ctc_top_icr = 1'b1;
            end
            `TCMO_WGM_FP8: begin
                cls = tcmo_pkg::TCMO_CLS_FAST; // R19
                top = `TCMO_TOP_8BIT; // R21
            end
            `TCMO_WGM_FP9: begin
                cls = tcmo_pkg::TCMO_CLS_FAST;
                top = `TCMO_TOP_9BIT; // R21
            end
            `TCMO_WGM_FP10: begin
                cls = tcmo_pkg::TCMO_CLS_FAST;
                top = `TCMO_TOP_10BIT; // R21
            end
            `TCMO_WGM_FP_ICR: begin
                cls = tcmo_pkg::TCMO_CLS_FAST;
                top = capture_reg; // R21
                ctc_top_icr = 1'b1;
            end
            `TCMO_WGM_FP_OCR: begin
                cls = tcmo_pkg::TCMO_CLS_FAST;
                top = ocr_reg; // R21
            end
            default: begin
                // Dual-slope modes are not built here; they count like normal mode
                cls = tcmo_pkg::TCMO_CLS_OTHER;
                top = `TCMO_CNT_MAX;
            end
        endcase
        // Exact equality: a top written below the count is missed until wrap
        at_top = (cnt_reg == top); // R16
        // A counter write blocks the match in the next timer cycle
        match = (cnt_reg == ocr_reg) && !blk_reg;
    end

    always_comb begin
        cnt_next = cnt_reg;
        ocr_next = ocr_reg;
        buf_next = buf_reg;
        tov_next = tov_reg && !overflow_clr; // R12
        ocf_next = ocf_reg && !match_clr;
        icf_next = icf_reg && !capture_clr;
        oc_next  = oc_reg;
        blk_next = blk_reg;
        if (compare_reg_wr) begin
            if (cls == tcmo_pkg::TCMO_CLS_FAST) begin
                buf_next = compare_reg_wdata; // R23
            end else begin
                ocr_next = compare_reg_wdata;
                buf_next = compare_reg_wdata;
            end
        end
        if (tick) begin
            blk_next = 1'b0;
            if (at_top && waveform_gen_mode != `TCMO_WGM_NORMAL) begin
                cnt_next = `TCMO_CNT_BOTTOM; // R14
            end else begin
                cnt_next = cnt_reg + 16'h0001; // R10
            end
            if (cls == tcmo_pkg::TCMO_CLS_FAST) begin
                if (at_top) begin
                    tov_next = 1'b1;
                    ocr_next = buf_reg; // R23
                    if (ctc_top_icr) begin
                        icf_next = 1'b1;
                    end
                end
            end else if (cnt_reg == `TCMO_CNT_MAX) begin
                tov_next = 1'b1; // R11 R18
            end
            if (cls == tcmo_pkg::TCMO_CLS_NONPWM && at_top
                    && waveform_gen_mode != `TCMO_WGM_NORMAL && ctc_top_icr) begin
                icf_next = 1'b1; // R15
            end
            if (match) begin
                ocf_next = 1'b1; // R15
                // Mode is sampled live, so a new value acts at the next match
                case (compare_output_mode_chan_a) // R7
                    `TCMO_COM_TOGGLE: oc_next = (cls == tcmo_pkg::TCMO_CLS_NONPWM
                        || waveform_gen_mode == `TCMO_WGM_FP_OCR) ? !oc_reg : oc_reg; // R17 R24
                    `TCMO_COM_CLEAR:  oc_next = (cls == tcmo_pkg::TCMO_CLS_FAST); // R20 R22 R24
                    `TCMO_COM_SET:    oc_next = (cls != tcmo_pkg::TCMO_CLS_FAST); // R20 R22 R24
                    default:          oc_next = oc_reg; // R6
                endcase
            end
            if (cls == tcmo_pkg::TCMO_CLS_FAST && at_top) begin
                if (compare_output_mode_chan_a == `TCMO_COM_CLEAR) begin
                    oc_next = 1'b0; // R20
                end else if (compare_output_mode_chan_a == `TCMO_COM_SET) begin
                    oc_next = 1'b1; // R20
                end
            end
        end
        if (cap_edge && !ctc_top_icr) begin
            icf_next = 1'b1; // R5
        end
        if (clk_en && force_compare_strobe && cls == tcmo_pkg::TCMO_CLS_NONPWM) begin
            case (compare_output_mode_chan_a) // R8 R4
                `TCMO_COM_TOGGLE: oc_next = !oc_reg;
                `TCMO_COM_CLEAR:  oc_next = 1'b0;
                `TCMO_COM_SET:    oc_next = 1'b1;
                default:          oc_next = oc_reg;
            endcase
        end
        if (clk_en && counter_wr) begin
            cnt_next = counter_wdata; // R13
            blk_next = 1'b1;
        end
        // Port path: compare state overrides port data, direction bit gates drive
        pout_next = (compare_output_mode_chan_a != `TCMO_COM_OFF) ? oc_next
                                                                  : port_out_bit; // R2
        poe_next  = pin_direction_bit; // R3
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= `TCMO_CNT_BOTTOM;
            ocr_reg  <= `TCMO_CNT_BOTTOM;
            buf_reg  <= `TCMO_CNT_BOTTOM;
            tov_reg  <= 1'b0;
            ocf_reg  <= 1'b0;
            icf_reg  <= 1'b0;
            oc_reg   <= `TCMO_OC_RST; // R1
            blk_reg  <= 1'b0;
            pout_reg <= 1'b0;
            poe_reg  <= 1'b0;
        end else if (clk_en) begin
            cnt_reg  <= cnt_next;
            ocr_reg  <= ocr_next;
            buf_reg  <= buf_next;
            tov_reg  <= tov_next;
            ocf_reg  <= ocf_next;
            icf_reg  <= icf_next;
            oc_reg   <= oc_next;
            blk_reg  <= blk_next;
            pout_reg <= pout_next;
            poe_reg  <= poe_next;
        end
    end

    assign counter_value               = cnt_reg;
    assign compare_reg_chan_a          = ocr_reg;
    assign overflow_flag               = tov_reg;
    assign match_flag_chan_a           = ocf_reg;
    assign capture_flag                = icf_reg;
    assign compare_output_state_chan_a = oc_reg;
    assign pin_out                     = pout_reg;
    assign pin_oe                      = poe_reg;
endmodule
`default_nettype wire

// File: test/tcmo_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcmo_port_model (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic dir_req,
    input  wire logic val_req,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_direction_bit,
    output logic      port_out_bit,
    output logic      pin_level
);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_direction_bit <= 1'b0;
            port_out_bit      <= 1'b0;
        end else begin
            pin_direction_bit <= dir_req;
            port_out_bit      <= val_req;
        end
    end
    // Pull-up holds an undriven pin high, so a missing drive is visible
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

// File: test/tcmo_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module tcmo_timer_props (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        timer_tick,
    input wire logic        counter_wr,
    input wire logic        overflow_clr,
    input wire logic        port_out_bit,
    input wire logic        pin_direction_bit,
    input wire logic [3:0]  waveform_gen_mode,
    input wire logic [1:0]  compare_output_mode_chan_a,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare_reg_chan_a,
    input wire logic        overflow_flag,
    input wire logic        match_flag_chan_a,
    input wire logic        compare_output_state_chan_a,
    input wire logic        pin_out,
    input wire logic        pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_ctc_top;
        timer_tick && !counter_wr && waveform_gen_mode == 4'h4 && counter_value == compare_reg_chan_a;
    endsequence
    sequence s_fast_top;
        timer_tick && !counter_wr && waveform_gen_mode == 4'h5 && counter_value == 16'h00ff;
    endsequence
    a_pin_source: assert property (pin_out == (($past(compare_output_mode_chan_a) != 2'h0) ?
        compare_output_state_chan_a : $past(port_out_bit))) else $error("pin source wrong");
    a_oe_dir: assert property (pin_oe == $past(pin_direction_bit))
        else $error("pin enable wrong");
    a_ovf_sticky: assert property ($fell(overflow_flag) |-> $past(overflow_clr))
        else $error("overflow flag dropped");
    a_normal_wrap: assert property (timer_tick && !counter_wr && waveform_gen_mode == 4'h0 &&
        counter_value == 16'hffff |=> counter_value == 16'h0000 && overflow_flag)
        else $error("normal wrap wrong");
    a_ctc_clear: assert property (s_ctc_top |=> counter_value == 16'h0000 && match_flag_chan_a)
        else $error("ctc clear wrong");
    a_ctc_toggle: assert property (compare_output_mode_chan_a == 2'h1 ##0 s_ctc_top |=>
        compare_output_state_chan_a != $past(compare_output_state_chan_a)) else $error("no toggle");
    a_fast_top: assert property (compare_output_mode_chan_a == 2'h2 ##0 s_fast_top |=>
        counter_value == 16'h0000 && overflow_flag && !compare_output_state_chan_a)
        else $error("fast top wrong");
    a_off_hold: assert property (compare_output_mode_chan_a == 2'h0 |=>
        $stable(compare_output_state_chan_a)) else $error("state moved");
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
    logic        clk_sys, rst_b, timer_tick, force_compare_strobe, counter_wr, compare_reg_wr;
    logic        overflow_clr, match_clr, dir_req, val_req, overflow_flag, match_flag_chan_a;
    logic        capture_flag, compare_output_state_chan_a, pin_out, pin_oe, pin_direction_bit;
    logic        port_out_bit, pin_level, ovf, mf, st, st0, po, oe, blk, m, fast;
    logic [3:0]  waveform_gen_mode;
    logic [1:0]  compare_output_mode_chan_a, c;
    logic [15:0] counter_wdata, compare_reg_wdata, counter_value, compare_reg_chan_a;
    int          cnt, ocr, obuf, top, n_errors, num_checks, seed = 32'h96806679;
    tcmo_timer tcmo_timer_i (.clk_en(1'b1), .capture_reg(16'h0000), .capture_clr(1'b0),
        .capture_event(1'b0), .*);
    tcmo_port_model tcmo_port_model_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Reference model; inputs are stable here since they move 1 ns after each edge
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {cnt, ocr, obuf, ovf, mf, st, po, oe, blk} = '0;
        end else begin
            c = compare_output_mode_chan_a;
            st0 = st;
            fast = waveform_gen_mode inside {4'h5, 4'hf};
            top = (waveform_gen_mode == 4'h5) ? 32'h00ff : ocr;
            m = (cnt == ocr) && !blk;
            if (overflow_clr) ovf = 1'b0;
            if (match_clr) mf = 1'b0;
            if (timer_tick) begin
                blk = 1'b0;
                mf |= m;
                if (m && !fast && c != 2'h0) st = (c == 2'h1) ? !st : c[0];
                if (m && fast && c[1]) st = !c[0];
                if (m && c == 2'h1 && waveform_gen_mode == 4'hf) st = !st;
                ovf |= !fast && (cnt == 32'hffff);
                if (waveform_gen_mode != 4'h0 && cnt == top) begin
                    cnt = 0;
                    ovf |= fast;
                    if (fast) ocr = obuf;
                    if (fast && c[1]) st = c[0];
                end else begin
                    cnt = (cnt + 1) & 32'hffff;
                end
            end
            // Force acts on the state seen before this edge and wins over a match
            if (force_compare_strobe && !fast && c != 2'h0) st = (c == 2'h1) ? !st0 : c[0];
            if (counter_wr) begin
                cnt = counter_wdata;
                blk = 1'b1;
            end
            if (compare_reg_wr) obuf = compare_reg_wdata;
            if (compare_reg_wr && !fast) ocr = compare_reg_wdata;
            po = (c != 2'h0) ? st : port_out_bit;
            oe = pin_direction_bit;
        end
    end
    always @(negedge clk_sys) begin
        `CHK("count", cnt, counter_value)
        `CHK("compare", ocr, compare_reg_chan_a)
        `CHK("overflow", ovf, overflow_flag)
        `CHK("match", mf, match_flag_chan_a)
        `CHK("capture", 1'b0, capture_flag)
        `CHK("state", st, compare_output_state_chan_a)
        `CHK("pin", oe ? po : 1'b1, pin_level)
    end
    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            timer_tick = 1'($random(seed));
            val_req = 1'($random(seed));
        end
    endtask
    // Strobe order: force, counter write, compare write, overflow clear, match clear
    task automatic pulse(input logic [4:0] s);
        {force_compare_strobe, counter_wr, compare_reg_wr, overflow_clr, match_clr} = s;
        cyc(1);
        {force_compare_strobe, counter_wr, compare_reg_wr, overflow_clr, match_clr} = 5'h00;
        cyc(1);
    endtask
    initial begin
        {timer_tick, force_compare_strobe, counter_wr, compare_reg_wr, overflow_clr} = '0;
        {match_clr, dir_req, val_req, rst_b, waveform_gen_mode} = '0;
        {compare_output_mode_chan_a, counter_wdata, compare_reg_wdata} = '0;
        cyc(10);
        rst_b = 1'b1;
        for (int i = 3; i < 7; i++) begin
            compare_output_mode_chan_a = 2'(i);
            pulse(5'h10);
            cyc(2);
        end
        dir_req = 1'b1;
        compare_output_mode_chan_a = 2'h3;
        compare_reg_wdata = 16'hfffe;
        counter_wdata = 16'hfff8;
        pulse(5'h0c);
        cyc(40);
        pulse(5'h03);
        counter_wdata = 16'hfff0;
        pulse(5'h08);
        cyc(4);
        waveform_gen_mode = 4'h4;
        compare_output_mode_chan_a = 2'h1;
        compare_reg_wdata = 16'h0003;
        pulse(5'h04);
        cyc(80);
        for (int i = 4; i < 8; i++) begin
            compare_output_mode_chan_a = 2'(i);
            cyc(20);
        end
        waveform_gen_mode = 4'h5;
        compare_output_mode_chan_a = 2'h2;
        compare_reg_wdata = 16'h0080;
        pulse(5'h04);
        pulse(5'h10);
        cyc(1200);
        compare_output_mode_chan_a = 2'h3;
        cyc(600);
        counter_wdata = 16'h0000;
        pulse(5'h08);
        waveform_gen_mode = 4'hf;
        compare_output_mode_chan_a = 2'h1;
        compare_reg_wdata = 16'h0005;
        pulse(5'h04);
        cyc(600);
        pulse(5'h03);
        rst_b = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        cyc(5);
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict;
    end
endmodule
bind tcmo_timer tcmo_timer_props tcmo_timer_props_i (.*);
`default_nettype wire
